// ===== src/psn_port_link.sv
// port start-up speed negotiation and link reset control with apb registers
//
// Behaviour
// - wait out line fault, negotiate, then operational
// - negotiation ends on sync plus fill
// - single speed sends 200 idles first
// - single speed: idles, Enabled, wait Ready
// - Enabled single speed sends fill until done
// - dual speed cycles 400,200,100,300 endlessly
// - each window: set rate, Disabled, idles; code goes to Idle instead
// - first window lasts 400 us
// - second window lasts 200 us
// - third window lasts 100 us
// - fourth window 300 us, then restart
// - window durations within ten percent
// - keep window deviation small
// - sync in window: Enabled, idles become fill
// - fill before expiry: Ready, else next window
// - link reset frame never forwarded
// - link reset status carries link status byte
// - link reset originated only in Check
// - sender ignores credit flag and sequence
// - receiver ignores credit flag and sequence
// - recognise link reset in Ready or Check
// - valid link reset: ack pair, enter Check
// - link reset leaves frame buffers alone
// - mode kept unless recovery ends in alert
module psn_port_link #(
    parameter int unsigned WIN0_CYCLES = psn_pkg::WIN0_CYC,
    parameter int unsigned WIN1_CYCLES = psn_pkg::WIN1_CYC,
    parameter int unsigned WIN2_CYCLES = psn_pkg::WIN2_CYC,
    parameter int unsigned WIN3_CYCLES = psn_pkg::WIN3_CYC,
    parameter int unsigned IDLE_CHARS  = psn_pkg::MIN_IDLE_CHARS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_char_clk,
    input  wire logic        line_fault,
    input  wire logic        char_sync,
    input  wire logic        fill_rx,
    input  wire logic        lr_rx_valid,
    input  wire logic [7:0]  lr_rx_status,
    output logic [5:0]       port_state,
    output logic             operational,
    output logic             normal_mode,
    output logic             tx_rate_hi,
    output logic             tx_send_fill,
    output logic             tx_ack_pair,
    output logic             tx_link_reset,
    output logic [7:0]       tx_lr_status
);
    // counts longer than the timer or idle counter cannot be served
    if (WIN0_CYCLES < 1 || WIN0_CYCLES >= (1 << psn_pkg::TIMER_W) ||
        WIN1_CYCLES < 1 || WIN1_CYCLES >= (1 << psn_pkg::TIMER_W) ||
        WIN2_CYCLES < 1 || WIN2_CYCLES >= (1 << psn_pkg::TIMER_W) ||
        WIN3_CYCLES < 1 || WIN3_CYCLES >= (1 << psn_pkg::TIMER_W) ||
        IDLE_CHARS < 1 || IDLE_CHARS > 255) begin : g_bad_param
        $error("psn_port_link: window or idle count out of range");
    end

    psn_pkg::psn_regs_t r_ff;
    psn_pkg::psn_regs_t nxt_r;

    logic                       wr_acc;
    logic                       start_cmd;
    logic                       lclk_edge;
    logic                       win_expired;
    logic [psn_pkg::TIMER_W-1:0] win_len;
    logic [1:0]                 win_next;
    logic                       fault_now;
    logic                       lr_take;
    logic                       fill_hit;
    logic                       in_search;
    logic                       addr_hit;
    logic                       setup_rd;

    // link clock idles low; a fault is assumed until the pin shows otherwise
    psn_pin_sync #(
        .RST_LEVEL(psn_pkg::RST_LCLK)
    ) u_lclk_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (link_char_clk),
        .level   (),
        .rise    (lclk_edge)
    );

    psn_pin_sync #(
        .RST_LEVEL(psn_pkg::RST_FAULT)
    ) u_fault_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (line_fault),
        .level   (fault_now),
        .rise    ()
    );

    // link reset is taken in Ready or Check only; buffer state plays no part
    assign lr_take   = lr_rx_valid &&
                       (r_ff.fsm == psn_pkg::PSN_READY || r_ff.fsm == psn_pkg::PSN_CHECK);
    assign fill_hit  = char_sync && fill_rx && (r_ff.fsm == psn_pkg::PSN_ENABLED);
    assign in_search = (r_ff.fsm == psn_pkg::PSN_IDLE) || (r_ff.fsm == psn_pkg::PSN_ENABLED);
    assign addr_hit  = (paddr == psn_pkg::OFS_CTRL) || (paddr == psn_pkg::OFS_STATUS) ||
                       (paddr == psn_pkg::OFS_LRTX) || (paddr == psn_pkg::OFS_LRRX);
    assign setup_rd  = psel && !penable && !pwrite;

    // window length per index, nominal so deviation stays zero
    function automatic logic [psn_pkg::TIMER_W-1:0] win_cycles(input logic [1:0] idx);
        unique case (idx)
            2'h0: win_cycles = psn_pkg::TIMER_W'(WIN0_CYCLES);
            2'h1: win_cycles = psn_pkg::TIMER_W'(WIN1_CYCLES);
            2'h2: win_cycles = psn_pkg::TIMER_W'(WIN2_CYCLES);
            2'h3: win_cycles = psn_pkg::TIMER_W'(WIN3_CYCLES);
        endcase
    endfunction : win_cycles

    always_comb begin
        nxt_r       = r_ff;
        wr_acc      = psel && penable && r_ff.pready && pwrite;
        start_cmd   = wr_acc && (paddr == psn_pkg::OFS_CTRL) && pwdata[psn_pkg::CTRL_START];
        win_next    = r_ff.win + 2'h1;
        win_len     = win_cycles(win_next);
        win_expired = r_ff.dual && (r_ff.timer == '0);

        // one-cycle pulses
        nxt_r.ack_pulse   = 1'b0;
        nxt_r.lr_tx_pulse = 1'b0;

        // window timer runs down in every dual speed window
        if (r_ff.timer != '0) begin
            nxt_r.timer = r_ff.timer - psn_pkg::TIMER_W'(1);
        end

        // idle character counter, saturates when the minimum is sent
        if (lclk_edge && !r_ff.idle_done) begin
            if (r_ff.idle_cnt == 8'(IDLE_CHARS - 1)) begin
                nxt_r.idle_done = 1'b1;
            end else begin
                nxt_r.idle_cnt = r_ff.idle_cnt + 8'h01;
            end
        end

        unique case (r_ff.fsm)
            psn_pkg::PSN_DISABLED: begin
                nxt_r.tx_fill = 1'b0;
            end
            psn_pkg::PSN_FAULT: begin
                if (!fault_now) begin
                    nxt_r.fsm       = psn_pkg::PSN_IDLE;
                    nxt_r.win       = 2'h0;
                    nxt_r.rate_hi   = 1'b1;
                    nxt_r.timer     = win_cycles(2'h0);
                    nxt_r.idle_cnt  = 8'h00;
                    nxt_r.idle_done = 1'b0;
                    nxt_r.tx_fill   = 1'b0;
                end
            end
            psn_pkg::PSN_IDLE: begin
                if (win_expired) begin
                    nxt_r.fsm = psn_pkg::PSN_IDLE;
                end else if (r_ff.idle_done && (!r_ff.dual || char_sync)) begin
                    // single speed goes Enabled after idles; dual waits for sync
                    nxt_r.fsm     = psn_pkg::PSN_ENABLED;
                    nxt_r.tx_fill = 1'b1;
                end
            end
            psn_pkg::PSN_ENABLED: begin
                if (char_sync && fill_rx) begin
                    // fill seen in time wins over an expiry in the same cycle
                    nxt_r.fsm         = psn_pkg::PSN_READY;
                    nxt_r.timer       = '0;
                    nxt_r.operational = 1'b1;
                end
            end
            psn_pkg::PSN_READY: begin
                nxt_r.tx_fill = 1'b1;
            end
            psn_pkg::PSN_CHECK: begin
                if (r_ff.lr_pending) begin
                    // no credit flag or sequence counter is consulted here
                    nxt_r.lr_tx_pulse = 1'b1;
                    nxt_r.lr_pending  = 1'b0;
                end
            end
        endcase

        // window expiry restarts the next window in Idle with idles
        if (win_expired && !fill_hit && in_search) begin
            nxt_r.fsm       = psn_pkg::PSN_IDLE;
            nxt_r.win       = win_next;
            nxt_r.rate_hi   = !win_next[0];
            nxt_r.timer     = win_len;
            nxt_r.idle_cnt  = 8'h00;
            nxt_r.idle_done = 1'b0;
            nxt_r.tx_fill   = 1'b0;
        end

        // link reset reception; buffer-full is deliberately not an input here
        if (lr_take) begin
            // frame is consumed locally, nothing goes to a router or buffer
            nxt_r.ack_pulse    = 1'b1;
            nxt_r.fsm          = psn_pkg::PSN_CHECK;
            nxt_r.lr_rx_status = lr_rx_status;
        end

        // apb register writes at the access edge
        if (wr_acc) begin
            unique case (paddr)
                psn_pkg::OFS_CTRL: begin
                    nxt_r.dual = pwdata[psn_pkg::CTRL_DUAL];
                    if (!pwdata[psn_pkg::CTRL_ERP_ALERT]) begin
                        nxt_r.normal_mode = pwdata[psn_pkg::CTRL_NORMAL];
                    end
                    if (pwdata[psn_pkg::CTRL_SEND_LR]) begin
                        nxt_r.lr_pending = 1'b1;
                    end
                    if (pwdata[psn_pkg::CTRL_ENTER_CHK] &&
                        (r_ff.fsm == psn_pkg::PSN_READY)) begin
                        nxt_r.fsm = psn_pkg::PSN_CHECK;
                    end
                    if (pwdata[psn_pkg::CTRL_ERP_OK] && (r_ff.fsm == psn_pkg::PSN_CHECK)) begin
                        nxt_r.fsm = psn_pkg::PSN_READY;
                    end
                    if (pwdata[psn_pkg::CTRL_ERP_ALERT]) begin
                        // alert exit: Disabled and privileged mode
                        nxt_r.fsm         = psn_pkg::PSN_DISABLED;
                        nxt_r.normal_mode = 1'b0;
                        nxt_r.operational = 1'b0;
                        nxt_r.timer       = '0;
                        nxt_r.lr_pending  = 1'b0;
                    end
                end
                psn_pkg::OFS_STATUS: begin
                    // received-link-reset flag is write one to clear; a new one wins
                    if (pwdata[psn_pkg::STAT_LR_SEEN]) begin
                        nxt_r.lr_seen = 1'b0;
                    end
                end
                psn_pkg::OFS_LRTX: begin
                    nxt_r.lr_tx_status = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end

        // start overrides the state and send link reset bits of the same write; dual and normal still load
        if (start_cmd) begin
            nxt_r.fsm         = psn_pkg::PSN_FAULT;
            nxt_r.operational = 1'b0;
            nxt_r.timer       = '0;
            nxt_r.lr_pending  = 1'b0;
            nxt_r.tx_fill     = 1'b0;
        end
        if (lr_take) begin
            nxt_r.lr_seen = 1'b1;
        end

        // apb answer: ready and read data prepared in the setup cycle
        nxt_r.pready  = psel && !penable;
        nxt_r.pslverr = psel && !penable && !addr_hit;
        nxt_r.prdata  = 32'h0000_0000;
        if (setup_rd) begin
            unique case (paddr)
                psn_pkg::OFS_CTRL: begin
                    nxt_r.prdata[psn_pkg::CTRL_DUAL]    = r_ff.dual;
                    nxt_r.prdata[psn_pkg::CTRL_SEND_LR] = r_ff.lr_pending;
                    nxt_r.prdata[psn_pkg::CTRL_NORMAL]  = r_ff.normal_mode;
                end
                psn_pkg::OFS_STATUS: begin
                    nxt_r.prdata[psn_pkg::STAT_STATE +: 6] = r_ff.fsm;
                    nxt_r.prdata[psn_pkg::STAT_OPER]       = r_ff.operational;
                    nxt_r.prdata[psn_pkg::STAT_RATE_HI]    = r_ff.rate_hi;
                    nxt_r.prdata[psn_pkg::STAT_WIN +: 2]   = r_ff.win;
                    nxt_r.prdata[psn_pkg::STAT_LR_SEEN]    = r_ff.lr_seen;
                    nxt_r.prdata[psn_pkg::STAT_FAULT]      = fault_now;
                    nxt_r.prdata[psn_pkg::STAT_SYNC]       = char_sync;
                end
                psn_pkg::OFS_LRTX: begin
                    nxt_r.prdata[7:0] = r_ff.lr_tx_status;
                end
                psn_pkg::OFS_LRRX: begin
                    nxt_r.prdata[7:0] = r_ff.lr_rx_status;
                end
                default: begin
                end
            endcase
        end
    end

    // every field named so no value after reset is left implicit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff.fsm          <= psn_pkg::PSN_DISABLED;
            r_ff.win          <= 2'h0;
            r_ff.timer        <= '0;
            r_ff.idle_cnt     <= 8'h00;
            r_ff.idle_done    <= 1'b0;
            r_ff.dual         <= psn_pkg::RST_DUAL;
            r_ff.normal_mode  <= psn_pkg::RST_NORMAL;
            r_ff.operational  <= 1'b0;
            r_ff.lr_pending   <= 1'b0;
            r_ff.lr_seen      <= 1'b0;
            r_ff.lr_tx_status <= 8'h00;
            r_ff.lr_rx_status <= 8'h00;
            r_ff.tx_fill      <= 1'b0;
            r_ff.rate_hi      <= psn_pkg::RST_RATE_HI;
            r_ff.ack_pulse    <= 1'b0;
            r_ff.lr_tx_pulse  <= 1'b0;
            r_ff.pready       <= 1'b0;
            r_ff.pslverr      <= 1'b0;
            r_ff.prdata       <= 32'h0000_0000;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign prdata        = r_ff.prdata;
    assign pready        = r_ff.pready;
    assign pslverr       = r_ff.pslverr;
    assign port_state    = r_ff.fsm;
    assign operational   = r_ff.operational;
    assign normal_mode   = r_ff.normal_mode;
    assign tx_rate_hi    = r_ff.rate_hi;
    assign tx_send_fill  = r_ff.tx_fill;
    assign tx_ack_pair   = r_ff.ack_pulse;
    assign tx_link_reset = r_ff.lr_tx_pulse;
    assign tx_lr_status  = r_ff.lr_tx_status;
endmodule : psn_port_link

// three-flop pin synchroniser: settled level and a one-cycle rise strobe
module psn_pin_sync #(
    parameter logic RST_LEVEL = 1'b0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    psn_pkg::psn_pin_t s_ff;
    psn_pkg::psn_pin_t nxt_s;

    // a change counts once stages two and three agree
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.sync = {s_ff.sync[1:0], pin};
        if (s_ff.sync[2] == s_ff.sync[1]) begin
            nxt_s.stable = s_ff.sync[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff.sync   <= {3{RST_LEVEL}};
            s_ff.stable <= RST_LEVEL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // rise stands only in the cycle before the settled level follows
    assign level = s_ff.stable;
    assign rise  = !s_ff.stable && (s_ff.sync[2] == s_ff.sync[1]) &&
                   s_ff.sync[2];
endmodule : psn_pin_sync

// ===== src/psn_pkg.sv
// constants and types for the port speed negotiation and link reset block
package psn_pkg;
    // clock and timing
    localparam int unsigned CLK_MHZ         = 40;
    localparam int unsigned WIN0_US         = 400;
    localparam int unsigned WIN1_US         = 200;
    localparam int unsigned WIN2_US         = 100;
    localparam int unsigned WIN3_US         = 300;
    localparam int unsigned WIN0_CYC        = WIN0_US * CLK_MHZ;
    localparam int unsigned WIN1_CYC        = WIN1_US * CLK_MHZ;
    localparam int unsigned WIN2_CYC        = WIN2_US * CLK_MHZ;
    localparam int unsigned WIN3_CYC        = WIN3_US * CLK_MHZ;
    localparam int unsigned MIN_IDLE_CHARS  = 200;
    localparam int unsigned TIMER_W         = 24;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LRTX   = 8'h08;
    localparam logic [7:0] OFS_LRRX   = 8'h0c;

    // control register fields
    localparam int unsigned CTRL_START      = 0;
    localparam int unsigned CTRL_DUAL       = 1;
    localparam int unsigned CTRL_SEND_LR    = 2;
    localparam int unsigned CTRL_ENTER_CHK  = 3;
    localparam int unsigned CTRL_ERP_OK     = 4;
    localparam int unsigned CTRL_ERP_ALERT  = 5;
    localparam int unsigned CTRL_NORMAL     = 6;

    // status register fields
    localparam int unsigned STAT_STATE      = 0;
    localparam int unsigned STAT_OPER       = 6;
    localparam int unsigned STAT_RATE_HI    = 7;
    localparam int unsigned STAT_WIN        = 8;
    localparam int unsigned STAT_LR_SEEN    = 10;
    localparam int unsigned STAT_FAULT      = 11;
    localparam int unsigned STAT_SYNC       = 12;

    // values after reset
    localparam logic RST_DUAL   = 1'b0;
    localparam logic RST_NORMAL = 1'b0;
    localparam logic RST_RATE_HI = 1'b1;
    localparam logic RST_LCLK    = 1'b0;
    localparam logic RST_FAULT   = 1'b1;

    typedef enum logic [5:0] {
        PSN_DISABLED = 6'h01,
        PSN_FAULT    = 6'h02,
        PSN_IDLE     = 6'h04,
        PSN_ENABLED  = 6'h08,
        PSN_READY    = 6'h10,
        PSN_CHECK    = 6'h20
    } psn_fsm_t;

    typedef struct packed {
        logic [2:0] sync;
        logic       stable;
    } psn_pin_t;

    typedef struct packed {
        psn_fsm_t           fsm;
        logic [1:0]         win;
        logic [TIMER_W-1:0] timer;
        logic [7:0]         idle_cnt;
        logic               idle_done;
        logic               dual;
        logic               normal_mode;
        logic               operational;
        logic               lr_pending;
        logic               lr_seen;
        logic [7:0]         lr_tx_status;
        logic [7:0]         lr_rx_status;
        logic               tx_fill;
        logic               rate_hi;
        logic               ack_pulse;
        logic               lr_tx_pulse;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } psn_regs_t;
endpackage : psn_pkg

// ===== test/psn_port_link_chk.sv
// concurrent checks on the port negotiation and link reset block
module psn_port_link_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       char_sync,
    input wire logic       fill_rx,
    input wire logic       lr_rx_valid,
    input wire logic [5:0] port_state,
    input wire logic       operational,
    input wire logic       normal_mode,
    input wire logic       tx_send_fill,
    input wire logic       tx_ack_pair,
    input wire logic       tx_link_reset
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ack_on_lr_a: assert property (
        lr_rx_valid && (port_state inside {6'h10, 6'h20}) |=> tx_ack_pair && port_state == 6'h20)
        else $error("no ack or no check after link reset");
    lr_ignored_a: assert property (
        lr_rx_valid && !(port_state inside {6'h10, 6'h20}) |=> !tx_ack_pair)
        else $error("link reset answered outside ready or check");
    lr_only_check_a: assert property (
        tx_link_reset |-> $past(port_state) == 6'h20)
        else $error("link reset sent outside check");
    oper_at_ready_a: assert property (
        $rose(operational) |-> port_state == 6'h10)
        else $error("operational set outside ready");
    idle_no_fill_a: assert property (
        port_state == 6'h04 |-> !tx_send_fill)
        else $error("fill sent while sending idles");
    fill_to_ready_a: assert property (
        port_state == 6'h08 && char_sync && fill_rx |=> port_state == 6'h10 && operational)
        else $error("fill in enabled did not reach ready");
    ready_by_fill_a: assert property (
        port_state == 6'h10 && $past(port_state) == 6'h08 |-> $past(char_sync && fill_rx))
        else $error("ready reached without sync and fill");
    mode_kept_a: assert property (
        lr_rx_valid |=> $stable(normal_mode))
        else $error("mode changed by link reset");
endmodule : psn_port_link_chk

bind psn_port_link psn_port_link_chk u_chk (
    .pclk(pclk), .presetn(presetn), .char_sync(char_sync), .fill_rx(fill_rx),
    .lr_rx_valid(lr_rx_valid), .port_state(port_state), .operational(operational),
    .normal_mode(normal_mode), .tx_send_fill(tx_send_fill), .tx_ack_pair(tx_ack_pair),
    .tx_link_reset(tx_link_reset)
);

// ===== test/psn_far_port.sv
// remote port model: character clock, decoder sync and fill strobe
module psn_far_port (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       rate_hi,
    input wire logic [1:0] accept,
    input wire logic [7:0] lag,
    input wire logic       fill_en,
    output logic           link_char_clk,
    output logic           char_sync,
    output logic           fill_rx
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt;
    logic       rate_q;
    logic [2:0] ph;
    logic       ok;
    // free running, odd offset so no phase tie to pclk
    initial begin
        link_char_clk = 1'b0;
        #37;
        forever #100 link_char_clk = ~link_char_clk;
    end
    assign ok = rate_hi ? accept[1] : accept[0];
    // sync lost on every rate change, regained lag plus two cycles later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            rate_q <= 1'b1;
            ph <= 3'h0;
            char_sync <= 1'b0;
            fill_rx <= 1'b0;
        end else begin
            rate_q <= rate_hi;
            ph <= ph + 3'h1;
            cnt <= (!ok || rate_q != rate_hi) ? 8'h00 : (cnt <= lag ? cnt + 8'h01 : cnt);
            char_sync <= ok && rate_q == rate_hi && cnt > lag;
            fill_rx <= char_sync && ok && fill_en && ph == 3'h0;
        end
    end
endmodule : psn_far_port

// ===== test/tb.sv
// self-checking bench for the port negotiation and link reset block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned IDLE = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, lr_rx_status, lag, b, tx_lr_status;
    logic [31:0] pwdata, prdata, q;
    logic        link_char_clk, line_fault, char_sync, fill_rx, lr_rx_valid, fill_en, r;
    logic        operational, normal_mode, tx_rate_hi, tx_send_fill, tx_ack_pair, tx_link_reset;
    logic [5:0]  port_state;
    logic [1:0]  accept;
    int          mismatches, compares, idle_n, n, i;

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // windows scaled down by 40, ratios kept
    psn_port_link #(.WIN0_CYCLES(400), .WIN1_CYCLES(200), .WIN2_CYCLES(100),
        .WIN3_CYCLES(300), .IDLE_CHARS(IDLE)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_char_clk(link_char_clk), .line_fault(line_fault), .char_sync(char_sync),
        .fill_rx(fill_rx), .lr_rx_valid(lr_rx_valid), .lr_rx_status(lr_rx_status),
        .port_state(port_state), .operational(operational), .normal_mode(normal_mode),
        .tx_rate_hi(tx_rate_hi), .tx_send_fill(tx_send_fill), .tx_ack_pair(tx_ack_pair),
        .tx_link_reset(tx_link_reset), .tx_lr_status(tx_lr_status));
    psn_far_port far (.pclk(pclk), .presetn(presetn), .rate_hi(tx_rate_hi), .accept(accept),
        .lag(lag), .fill_en(fill_en), .link_char_clk(link_char_clk), .char_sync(char_sync),
        .fill_rx(fill_rx));

    function automatic int win_len(input int k);
        return k == 0 ? 400 : k == 1 ? 200 : k == 2 ? 100 : 300;
    endfunction : win_len

    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // master waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_st(input logic [5:0] s, input int lim);
        int k;
        for (k = 0; k < lim && port_state !== s; k++) @(posedge pclk);
        chk(port_state, s);
    endtask : wait_st

    task automatic pulse_lr(input logic exp);
        @(posedge pclk);
        lr_rx_status <= 8'($urandom);
        lr_rx_valid <= 1'b1;
        @(posedge pclk);
        lr_rx_valid <= 1'b0;
        @(posedge pclk);
        chk(tx_ack_pair, exp);
        @(posedge pclk);
    endtask : pulse_lr

    // idles on the wire since the fault cleared
    always @(posedge link_char_clk) if (tx_send_fill === 1'b0 && line_fault === 1'b0) idle_n++;
    always @(posedge pclk) if (line_fault === 1'b1) idle_n = 0;

    initial begin
        #2_000_000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        {psel, penable, pwrite, lr_rx_valid, fill_en, err} = 6'h00;
        {paddr, lr_rx_status, lag, pwdata, q} = '0;
        {line_fault, presetn, accept} = 4'b1000;
        {mismatches, compares, idle_n} = '0;
        n = $urandom(30829);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(port_state, 6'h01);
        apb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h881);
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({q[30:0], err}, 32'h1);
        // single speed, start held off by a line fault
        apb(1'b1, 8'h00, 32'h1);
        repeat (20) @(posedge pclk);
        chk(port_state, 6'h02);
        line_fault <= 1'b0;
        wait_st(6'h08, 2000);
        chk(tx_send_fill, 1'b1);
        chk(idle_n >= IDLE, 1'b1);
        pulse_lr(1'b0);
        chk(port_state, 6'h08);
        accept <= 2'b11;
        fill_en <= 1'b1;
        lag <= 8'($urandom % 20);
        wait_st(6'h10, 2000);
        chk(operational, 1'b1);
        apb(1'b1, 8'h00, 32'h40);
        pulse_lr(1'b1);
        chk(port_state, 6'h20);
        chk(normal_mode, 1'b1);
        apb(1'b0, 8'h0c, 32'h0);
        chk(q, {24'h0, lr_rx_status});
        b = 8'($urandom);
        apb(1'b1, 8'h08, {24'h0, b});
        apb(1'b0, 8'h08, 32'h0);
        chk(q, {24'h0, b});
        apb(1'b1, 8'h00, 32'h44);
        for (n = 0; n < 50 && tx_link_reset !== 1'b1; n++) @(posedge pclk);
        chk(tx_link_reset, 1'b1);
        chk(tx_lr_status, b);
        apb(1'b1, 8'h00, 32'h50);
        wait_st(6'h10, 50);
        chk(normal_mode, 1'b1);
        apb(1'b1, 8'h00, 32'h20);
        wait_st(6'h01, 50);
        chk({normal_mode, operational}, 2'b00);
        // dual speed with no remote sync: watch the window cycle
        accept <= 2'b00;
        apb(1'b1, 8'h00, 32'h3);
        for (i = 0; i < 5; i++) begin
            r = tx_rate_hi;
            for (n = 0; n < 2000 && tx_rate_hi === r; n++) @(posedge pclk);
            chk(tx_rate_hi, i % 2);
            chk({tx_send_fill, port_state}, 7'h04);
            // tighter than the allowed tolerance, timing is nominal
            if (i > 0) chk(n >= win_len(i % 4) - 2 && n <= win_len(i % 4) + 2, 1'b1);
        end
        accept <= 2'b01;
        lag <= 8'($urandom % 20);
        wait_st(6'h10, 3000);
        chk({tx_rate_hi, operational}, 2'b01);
        tally_and_finish();
    end
endmodule : tb
